/* rtl/xpt_consts.vh */
`ifndef XPT_CONSTS_VH
`define XPT_CONSTS_VH
// slot layout: enable bit above a four-bit input selector
`define SLOT_W 5
`define SLOT_EN_BIT 4
`define SEL_W 4
`define NUM_SLOTS 9
`define NUM_INPUTS 16
`define IMAGE_W 45
// reset value of the second rank: all outputs disabled
`define RANK2_RST 45'h0
`define RANK1_RST 45'h0
`endif

/* rtl/edge_sync.v */
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser with a fall detector on the settled copy
module edge_sync (
  input wire clk,
  input wire rst_b,
  input wire pin,
  output wire level,
  output wire fall
);
  reg meta_q; // first stage, read only by sync_q
  reg sync_q; // settled level
  reg prev_q; // settled level one cycle older
  // pins idle high; reset to high so no false fall after release
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign fall = prev_q & ~sync_q;
endmodule
`default_nettype wire

/* rtl/slot_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "xpt_consts.vh"
// one-hot decode of a slot: exactly one input or none
module slot_decode (
  input wire [`SLOT_W-1:0] slot,
  output wire [`NUM_INPUTS-1:0] onehot
);
  genvar i;
  generate
    for (i = 0; i < `NUM_INPUTS; i = i + 1) begin : g_in
      // disabled slot selects nothing regardless of selector bits
      // selector code of this input, sized to the selector field
      localparam [`SEL_W-1:0] IDX = i;
      assign onehot[i] = slot[`SLOT_EN_BIT] & (slot[`SEL_W-1:0] == IDX);
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/crosspoint_program_latches.v */
`timescale 1ns/100ps
`default_nettype none
`include "xpt_consts.vh"
module crosspoint_program_latches (
  input wire clk,
  input wire rst_b,
  input wire write_strobe_b,
  input wire update_b,
  input wire serial_clk_b,
  input wire serial_in_pin,
  input wire serial_parallel_select,
  input wire chip_select_b,
  input wire cm_encoding_pass,
  input wire [`SLOT_W-1:0] slot_data,
  input wire [`SEL_W-1:0] slot_address,
  output reg serial_out_pin,
  output reg [`NUM_SLOTS-1:0] output_enable,
  output reg [`NUM_SLOTS*`NUM_INPUTS-1:0] input_select_onehot,
  output reg cm_pass_mode,
  output reg [`IMAGE_W-1:0] active_image
);
  // synchronised control pins
  wire we_b_s;
  wire we_fall;
  wire upd_b_s;
  wire sclk_fall;
  wire cs_b_s;
  wire sp_s;
  wire din_s;
  wire cm_s;
  wire [`SLOT_W-1:0] data_s;
  wire [`SEL_W-1:0] addr_s;
  wire serial_in_pin_s; // settled serial data, declared before the alias below
  reg [`SLOT_W-1:0] data_m_q; // first stage for data bus
  reg [`SLOT_W-1:0] data_q;
  reg [`SEL_W-1:0] addr_m_q; // first stage for address bus
  reg [`SEL_W-1:0] addr_q;
  reg [2:0] misc_m_q; // first stage: chip select, mode, serial/parallel select
  reg [2:0] misc_q;
  reg upd_m_q;
  reg upd_q;
  // first rank (shift register) and second rank
  reg [`IMAGE_W-1:0] rank1_q;
  reg [`IMAGE_W-1:0] rank1_d;
  reg [`IMAGE_W-1:0] rank2_q;
  wire [`NUM_SLOTS*`NUM_INPUTS-1:0] onehot_w;
  wire [`IMAGE_W-1:0] bcast_w;
  integer k;

  // write strobe and serial clock need edges; use the edge synchroniser
  edge_sync u_we (
    .clk(clk),
    .rst_b(rst_b),
    .pin(write_strobe_b),
    .level(we_b_s),
    .fall(we_fall)
  );
  edge_sync u_sclk (
    .clk(clk),
    .rst_b(rst_b),
    .pin(serial_clk_b),
    .level(),
    .fall(sclk_fall)
  );

  // plain two-flop synchronisers for levels; buses assumed stable at strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_m_q <= 5'h00;
      data_q <= 5'h00;
      addr_m_q <= 4'h0;
      addr_q <= 4'h0;
      misc_m_q <= 3'h4;
      misc_q <= 3'h4;
      upd_m_q <= 1'b1;
      upd_q <= 1'b1;
    end else begin
      data_m_q <= slot_data;
      data_q <= data_m_q;
      addr_m_q <= slot_address;
      addr_q <= addr_m_q;
      misc_m_q <= {chip_select_b, cm_encoding_pass, serial_parallel_select};
      misc_q <= misc_m_q;
      upd_m_q <= update_b;
      upd_q <= upd_m_q;
    end
  end
  assign data_s = data_q;
  assign addr_s = addr_q;
  assign cs_b_s = misc_q[2];
  assign cm_s = misc_q[1];
  assign sp_s = misc_q[0];
  assign upd_b_s = upd_q;
  assign din_s = serial_in_pin_s;

  // serial input needs its own pair so it lines up with the clock fall
  reg sin_m_q;
  reg sin_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sin_m_q <= 1'b0;
      sin_q <= 1'b0;
    end else begin
      sin_m_q <= serial_in_pin;
      sin_q <= sin_m_q;
    end
  end
  assign serial_in_pin_s = sin_q;

  // broadcast image: the same slot repeated nine times
  genvar s;
  generate
    for (s = 0; s < `NUM_SLOTS; s = s + 1) begin : g_bc
      assign bcast_w[s*`SLOT_W +: `SLOT_W] = data_s;
    end
  endgenerate

  // next first-rank contents; only writes change it, never the switch array
  always @* begin
    rank1_d = rank1_q;
    if (!sp_s) begin
      if (!cs_b_s && upd_b_s) begin
        if (!we_b_s) begin
          // broadcast held while strobe low
          rank1_d = bcast_w;
        end else if (sclk_fall) begin
          // shift toward slot 8 end; msb leaves on the serial output
          rank1_d = {rank1_q[`IMAGE_W-2:0], din_s};
        end
      end
    end else if (we_fall && upd_b_s) begin
      // parallel write on strobe fall, chip select not looked at
      for (k = 0; k < `NUM_SLOTS; k = k + 1) begin
        if (addr_s == k[`SEL_W-1:0]) begin
          rank1_d[k*`SLOT_W +: `SLOT_W] = data_s;
        end
      end
    end
  end

  // first rank has no reset path from rst_b activity beyond power-up value
  always @(posedge clk) begin
    rank1_q <= rank1_d;
  end
  initial rank1_q = `RANK1_RST;

  // second rank: follows first rank while update low, chip selected and write strobe high
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rank2_q <= `RANK2_RST;
    end else if (!upd_b_s && !cs_b_s && we_b_s) begin
      rank2_q <= rank1_q;
    end
  end

  // per-output decode of the second rank
  generate
    for (s = 0; s < `NUM_SLOTS; s = s + 1) begin : g_dec
      slot_decode u_dec (
        .slot(rank2_q[s*`SLOT_W +: `SLOT_W]),
        .onehot(onehot_w[s*`NUM_INPUTS +: `NUM_INPUTS])
      );
    end
  endgenerate

  // registered outputs; cleared with the second rank so disable is immediate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serial_out_pin <= 1'b0;
      output_enable <= 9'h000;
      input_select_onehot <= 144'h0;
      cm_pass_mode <= 1'b0;
      active_image <= `RANK2_RST;
    end else begin
      serial_out_pin <= rank1_q[`IMAGE_W-1];
      for (k = 0; k < `NUM_SLOTS; k = k + 1) begin
        output_enable[k] <= rank2_q[k*`SLOT_W + `SLOT_EN_BIT];
      end
      input_select_onehot <= onehot_w;
      cm_pass_mode <= cm_s;
      active_image <= rank2_q;
    end
  end
endmodule
`default_nettype wire

/* verification/xpt_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
`include "xpt_consts.vh"
// watches the pins only; strobes need several clocks to pass the synchronisers
module xpt_monitor (
  input wire logic clk, rst_b, write_strobe_b, update_b, serial_clk_b, chip_select_b,
  input wire logic cm_encoding_pass, serial_out_pin, cm_pass_mode,
  input wire logic [`NUM_SLOTS-1:0] output_enable,
  input wire logic [`NUM_SLOTS*`NUM_INPUTS-1:0] input_select_onehot,
  input wire logic [`IMAGE_W-1:0] active_image
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // deselected and no strobe long enough for the synchronisers to settle
  sequence cs_idle; (chip_select_b && write_strobe_b)[*5]; endsequence
  // update held with nothing feeding the first rank
  sequence quiet_upd; (!update_b && !chip_select_b && write_strobe_b && $stable(serial_clk_b))[*6];
  endsequence
  a_reset_clear: assert property ($rose(rst_b) |-> active_image == 0 && output_enable == 0)
    else $error("outputs live after reset");
  a_upd_idle: assert property (update_b[*5] |=> $stable(active_image))
    else $error("outputs moved without update");
  a_cs_gate: assert property (chip_select_b[*5] |=> $stable(active_image))
    else $error("update passed while deselected");
  a_cs_shift: assert property (cs_idle |=> $stable(serial_out_pin))
    else $error("shift while deselected");
  a_cm_follow: assert property ($stable(cm_encoding_pass)[*5] |-> cm_pass_mode == cm_encoding_pass)
    else $error("mode not followed");
  a_one_sel: assert property ($onehot0(input_select_onehot[15:0]))
    else $error("several inputs on one output");
  a_off_quiet: assert property (!output_enable[8] |-> input_select_onehot[143:128] == 0)
    else $error("disabled output selects input");
  a_transparent: assert property (quiet_upd |=> $stable(active_image))
    else $error("steady image not held");
endmodule
bind crosspoint_program_latches xpt_monitor xpt_monitor_inst (.*);
`default_nettype wire

/* verification/prog_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// programming controller; levels change after a falling clk and hold >= 4 clocks
module prog_ctrl (
  input wire logic clk,
  output logic write_strobe_b, update_b, serial_clk_b, serial_in_pin,
  output logic serial_parallel_select, chip_select_b,
  output logic [4:0] slot_data,
  output logic [3:0] slot_address
);
  task automatic hold(input int n); repeat (n) @(negedge clk); endtask
  initial begin
    {write_strobe_b, update_b, serial_clk_b, chip_select_b} = 4'hF;
    {serial_in_pin, serial_parallel_select, slot_data, slot_address} = 11'h0;
  end
  // whole image every time, msb first, one bit per serial clock fall (eight clk periods per bit)
  task automatic shift(input logic [44:0] v);
    chip_select_b = 0;
    serial_parallel_select = 0;
    for (int i = 44; i >= 0; i--) begin
      serial_in_pin = v[i];
      hold(4);
      serial_clk_b = 0;
      hold(4);
      serial_clk_b = 1;
    end
    serial_in_pin = ~v[0]; // released line does not keep the last bit
    hold(4);
  endtask
  // slot write or broadcast; data settles before the strobe falls
  task automatic strobe(input logic par, input logic [3:0] a, input logic [4:0] d, input logic cs);
    {serial_parallel_select, slot_address, slot_data, chip_select_b} = {par, a, d, cs};
    hold(4);
    write_strobe_b = 0;
    hold(4);
    write_strobe_b = 1;
    hold(4);
  endtask
  task automatic update(input logic cs);
    chip_select_b = cs;
    hold(4);
    update_b = 0;
    hold(6);
    update_b = 1;
    hold(6);
  endtask
endmodule
`default_nettype wire

/* verification/crosspoint_program_latches_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module crosspoint_program_latches_tb;
  logic clk = 0, rst_b = 0, cm_encoding_pass = 0;
  wire write_strobe_b, update_b, serial_clk_b, serial_in_pin, serial_parallel_select;
  wire chip_select_b, serial_out_pin, cm_pass_mode;
  wire [4:0] slot_data;
  wire [3:0] slot_address;
  wire [8:0] output_enable;
  wire [143:0] input_select_onehot;
  wire [44:0] active_image;
  int err_total = 0, total_checks = 0, seed = 32'hA234;
  logic [44:0] r1 = 0, img; // first rank as the bench expects it
  logic [4:0] d;
  always #50 clk = ~clk;
  crosspoint_program_latches crosspoint_program_latches_inst (.*);
  prog_ctrl prog_ctrl_inst (.*);
  task automatic chk(input logic [44:0] g, input logic [44:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin #500000; err_total++; conclude; end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    chk(active_image, 0);
    img = 45'({$random(seed), $random(seed)});
    prog_ctrl_inst.shift(img);
    r1 = img;
    cm_encoding_pass = 1;
    chk(active_image, 0);
    chk(45'(serial_out_pin), 45'(img[44]));
    prog_ctrl_inst.update(1);
    chk(active_image, 0);
    prog_ctrl_inst.update(0);
    chk(active_image, r1);
    for (int s = 0; s < 9; s++) chk(45'(output_enable[s]), 45'(r1[5*s+4]));
    for (int s = 0; s < 9; s++) begin
      chk(45'(input_select_onehot[16*s+:16]), r1[5*s+4] ? 45'(16'h1 << r1[5*s+:4]) : 45'h0);
    end
    rst_b = 0;
    @(negedge clk);
    rst_b = 1;
    repeat (3) @(negedge clk);
    chk(active_image, 0);
    prog_ctrl_inst.update(0);
    chk(active_image, r1);
    img = r1;
    for (int k = 0; k < 16; k++) begin
      d = 5'($random(seed));
      prog_ctrl_inst.strobe(1, k[3:0], d, 1'($random(seed)));
      if (k < 9) r1[5*k+:5] = d;
    end
    chk(active_image, img);
    prog_ctrl_inst.update(0);
    chk(active_image, r1);
    d = 5'($random(seed));
    prog_ctrl_inst.strobe(0, 4'h0, d, 0);
    r1 = {9{d}};
    chk(45'(serial_out_pin), 45'(d[4]));
    prog_ctrl_inst.update(0);
    chk(active_image, r1);
    chk(45'(cm_pass_mode), 45'h1);
    conclude;
  end
endmodule
`default_nettype wire
